// *** core/bmsr_check_word.sv ***
// Check word over the section-three spare words
`timescale 1ns/100ps
module bmsr_check_word
  import bmsr_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        sync_clear_i,
  // Words covered
  input  wire logic [15:0] word_a_i,
  input  wire logic [15:0] word_high_i,
  input  wire logic [15:0] word_b_i,
  // Result
  output logic      [15:0] check_o
);

  logic [15:0] next_check;

  function automatic logic [15:0] fold_word(input logic [15:0] crc, input logic [15:0] w);
    logic [15:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ w[i]) ? ((c << 1) ^ CHECK_POLY) : (c << 1);
    end
    return c;
  endfunction

  always_comb begin
    next_check = fold_word(fold_word(fold_word(CHECK_SEED, word_a_i), word_high_i), word_b_i);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      check_o <= RESET_WORD;
    end else if (sync_clear_i) begin
      check_o <= RESET_WORD;
    end else begin
      check_o <= next_check;
    end
  end

endmodule

// *** core/bmsr_pkg.sv ***
// Package: constants and carriers for the section-three spare register bank
package bmsr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0]  ADDR_SPARE_A    = 8'he1;
  localparam logic [7:0]  ADDR_SPARE_HIGH = 8'he2;
  localparam logic [7:0]  ADDR_SPARE_B    = 8'he3;
  localparam logic [7:0]  ADDR_CHECK      = 8'hfe;
  localparam logic [15:0] RESET_WORD      = 16'h0000;
  localparam logic [15:0] HIGH_KEEP_MASK  = 16'hff00;

  // ----------------------------------------
  // Check word
  // ----------------------------------------
  localparam logic [15:0] CHECK_POLY      = 16'h1021;
  localparam logic [15:0] CHECK_SEED      = 16'hffff;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int OVERSAMPLING     = 1024;
  localparam int CONV_TIME_NS     = 750000;
  localparam int CONV_CYCLES      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_LOW_CYCLES = 4;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } bmsr_req_t;

  typedef enum logic [2:0] {
    CONV_IDLE  = 3'b001,
    CONV_RUN   = 3'b010,
    CONV_DONE  = 3'b100
  } bmsr_conv_t;

endpackage

// *** core/bmsr_top.sv ***
// Spare register bank, section check value and result-ready timing
`timescale 1ns/100ps
module bmsr_top
  import bmsr_pkg::*;
#(
  parameter int CONV_COUNT = CONV_CYCLES
)(
  // Clock and resets
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        hardware_reset_low_i,
  // Register access from the serial frame decoder
  input  wire logic        chip_select_low_i,
  input  wire bmsr_req_t   req_i,
  output logic             ack_o,
  output logic      [15:0] rdata_o,
  // Conversion events
  input  wire logic        conv_run_i,
  input  wire logic        current_converter_a_done_i,
  input  wire logic        current_converter_b_done_i,
  output logic             result_ready_low_o,
  // Section check
  output logic      [15:0] section_check_o,
  output logic             check_match_o
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0] spare_scratch_word_a;
  logic [15:0] spare_scratch_high_byte;
  logic [15:0] spare_scratch_word_b;
  logic [15:0] section_three_check_value;
  logic [15:0] next_word_a;
  logic [15:0] next_high;
  logic [15:0] next_word_b;
  logic [15:0] next_check_value;
  logic [15:0] next_rdata;
  logic        next_ack;
  logic        take;
  logic        sync_clear;

  function automatic logic [15:0] read_word(input logic [7:0] a, input logic [15:0] wa,
                                            input logic [15:0] wh, input logic [15:0] wb,
                                            input logic [15:0] cv);
    unique case (a)
      ADDR_SPARE_A:    return wa;
      ADDR_SPARE_HIGH: return wh & HIGH_KEEP_MASK;
      ADDR_SPARE_B:    return wb;
      ADDR_CHECK:      return cv;
      default:         return RESET_WORD;
    endcase
  endfunction

  // Transfers only count while the host holds the part selected
  assign take       = req_i.valid && !chip_select_low_i;
  assign sync_clear = !hardware_reset_low_i;

  always_comb begin
    next_word_a      = spare_scratch_word_a;
    next_high        = spare_scratch_high_byte;
    next_word_b      = spare_scratch_word_b;
    next_check_value = section_three_check_value;
    next_rdata       = rdata_o;
    next_ack         = take;
    if (take && req_i.write) begin
      unique case (req_i.addr)
        ADDR_SPARE_A:    next_word_a      = req_i.wdata;
        ADDR_SPARE_HIGH: next_high        = req_i.wdata & HIGH_KEEP_MASK;
        ADDR_SPARE_B:    next_word_b      = req_i.wdata;
        ADDR_CHECK:      next_check_value = req_i.wdata;
        default:         next_word_a      = spare_scratch_word_a;
      endcase
    end else if (take) begin
      next_rdata = read_word(req_i.addr, spare_scratch_word_a, spare_scratch_high_byte,
                             spare_scratch_word_b, section_three_check_value);
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      spare_scratch_word_a      <= RESET_WORD;
      spare_scratch_high_byte   <= RESET_WORD;
      spare_scratch_word_b      <= RESET_WORD;
      section_three_check_value <= RESET_WORD;
      rdata_o                   <= RESET_WORD;
      ack_o                     <= 1'b0;
    end else if (sync_clear) begin
      spare_scratch_word_a      <= RESET_WORD;
      spare_scratch_high_byte   <= RESET_WORD;
      spare_scratch_word_b      <= RESET_WORD;
      section_three_check_value <= RESET_WORD;
      rdata_o                   <= RESET_WORD;
      ack_o                     <= 1'b0;
    end else begin
      spare_scratch_word_a      <= next_word_a;
      spare_scratch_high_byte   <= next_high;
      spare_scratch_word_b      <= next_word_b;
      section_three_check_value <= next_check_value;
      rdata_o                   <= next_rdata;
      ack_o                     <= next_ack;
    end
  end

  // ----------------------------------------
  // Section check
  // ----------------------------------------
  bmsr_check_word u_check (
    .clock_i      (clock_i),
    .arst_n_i     (arst_n_i),
    .sync_clear_i (sync_clear),
    .word_a_i     (spare_scratch_word_a),
    .word_high_i  (spare_scratch_high_byte),
    .word_b_i     (spare_scratch_word_b),
    .check_o      (section_check_o)
  );

  logic next_match;

  always_comb begin
    next_match = (section_check_o == section_three_check_value);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      check_match_o <= 1'b0;
    end else if (sync_clear) begin
      check_match_o <= 1'b0;
    end else begin
      check_match_o <= next_match;
    end
  end

  // ----------------------------------------
  // Conversion timer and ready output
  // ----------------------------------------
  bmsr_conv_t  state;
  bmsr_conv_t  next_state;
  logic [15:0] conv_cnt;
  logic [15:0] next_conv_cnt;
  logic [2:0]  low_cnt;
  logic [2:0]  next_low_cnt;
  logic        next_ready_low;
  logic        fire;

  // Spare contents never reach this path, so they cannot disturb results
  always_comb begin
    next_state    = state;
    next_conv_cnt = conv_cnt;
    fire          = 1'b0;
    unique case (state)
      CONV_IDLE: begin
        next_conv_cnt = 16'h0000;
        if (conv_run_i) begin
          next_state = CONV_RUN;
        end
      end
      CONV_RUN: begin
        if (!conv_run_i) begin
          next_state = CONV_IDLE;
        end else if (conv_cnt == 16'(CONV_COUNT - 1)) begin
          next_state = CONV_DONE;
        end else begin
          next_conv_cnt = conv_cnt + 16'h0001;
        end
      end
      CONV_DONE: begin
        fire          = 1'b1;
        // Done cycle is the first tick of the next conversion, so the period is
        // CONV_COUNT cycles; CONV_COUNT must therefore be at least 2
        next_conv_cnt = conv_run_i ? 16'h0001 : 16'h0000;
        next_state    = conv_run_i ? CONV_RUN : CONV_IDLE;
      end
      default: begin
        next_state    = CONV_IDLE;
        next_conv_cnt = 16'h0000;
      end
    endcase
  end

  // New event restarts the low pulse so none is swallowed
  always_comb begin
    if (fire || current_converter_a_done_i || current_converter_b_done_i) begin
      next_low_cnt = 3'(READY_LOW_CYCLES);
    end else if (low_cnt != 3'h0) begin
      next_low_cnt = low_cnt - 3'h1;
    end else begin
      next_low_cnt = 3'h0;
    end
    next_ready_low = (next_low_cnt == 3'h0);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state              <= CONV_IDLE;
      conv_cnt           <= 16'h0000;
      low_cnt            <= 3'h0;
      result_ready_low_o <= 1'b1;
    end else if (sync_clear) begin
      state              <= CONV_IDLE;
      conv_cnt           <= 16'h0000;
      low_cnt            <= 3'h0;
      result_ready_low_o <= 1'b1;
    end else begin
      state              <= next_state;
      conv_cnt           <= next_conv_cnt;
      low_cnt            <= next_low_cnt;
      result_ready_low_o <= next_ready_low;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_take_read;
    take && !req_i.write && hardware_reset_low_i;
  endsequence

  // Nothing may restart or cut the pulse inside this window
  sequence s_quiet_window;
    (hardware_reset_low_i && !current_converter_a_done_i && !current_converter_b_done_i
     && !fire) [*4];
  endsequence

  // Low for four samples, high again on the fifth
  sequence s_ready_pulse;
    !result_ready_low_o && !$past(result_ready_low_o) && !$past(result_ready_low_o, 2)
    && !$past(result_ready_low_o, 3) ##1 result_ready_low_o;
  endsequence

  a_high_low_zero: assert property (
    s_take_read ##0 (req_i.addr == ADDR_SPARE_HIGH) |=> rdata_o[7:0] == 8'h00)
    else $error("reserved low byte read back non-zero");

  a_write_a_holds: assert property (
    take && req_i.write && req_i.addr == ADDR_SPARE_A && hardware_reset_low_i
    |=> spare_scratch_word_a == $past(req_i.wdata))
    else $error("spare word a did not keep written value");

  a_check_rw: assert property (
    take && req_i.write && req_i.addr == ADDR_CHECK && hardware_reset_low_i
    |=> section_three_check_value == $past(req_i.wdata))
    else $error("check value did not keep written value");

  a_check_read: assert property (
    s_take_read ##0 (req_i.addr == ADDR_CHECK)
    |=> rdata_o == $past(section_three_check_value))
    else $error("check value read back differs");

  a_spare_to_check: assert property (
    take && req_i.write && req_i.addr == ADDR_SPARE_B && hardware_reset_low_i
    && req_i.wdata != spare_scratch_word_b ##1 hardware_reset_low_i
    |=> section_check_o != $past(section_check_o))
    else $error("spare write left section check unchanged");

  a_hw_reset_init: assert property (
    !hardware_reset_low_i |=> spare_scratch_word_a == 16'h0000
    && section_three_check_value == 16'h0000 && result_ready_low_o && state == CONV_IDLE)
    else $error("hardware reset did not restore initial state");

  a_access_acked: assert property (
    take && hardware_reset_low_i |=> ack_o)
    else $error("taken access was not acknowledged");

  a_deselect_idle: assert property (
    chip_select_low_i |=> !ack_o)
    else $error("access acknowledged while deselected");

  a_ready_on_event: assert property (
    (current_converter_a_done_i || current_converter_b_done_i || fire) && hardware_reset_low_i
    ##1 s_quiet_window |-> s_ready_pulse)
    else $error("converter result not flagged on ready output");

  a_ready_falls: assert property (
    (current_converter_a_done_i || current_converter_b_done_i || fire) && hardware_reset_low_i
    |=> !result_ready_low_o)
    else $error("ready output did not fall after a result");

  a_conv_time: assert property (
    state == CONV_DONE |-> $past(conv_cnt) == 16'(CONV_COUNT - 1))
    else $error("conversion finished at wrong count");

endmodule

// *** verif/bmsr_host.sv ***
// Host model driving the register access side of the bank
`timescale 1ns/100ps
module bmsr_host
  import bmsr_pkg::*;
(
  // Clock
  input  wire logic        clock_i,
  // Answer from the bank
  input  wire logic        ack_i,
  input  wire logic [15:0] rdata_i,
  // Request towards the bank
  output logic             chip_select_low_o,
  output bmsr_req_t        req_o
);
  initial begin
    chip_select_low_o = 1'b1;
    req_o             = '0;
  end

  // One access per select window; a refused try keeps select high
  task automatic access(input logic sel, input logic wr, input logic [7:0] a,
                        input logic [15:0] d, output logic ok, output logic [15:0] q);
    @(posedge clock_i);
    chip_select_low_o <= ~sel;
    @(posedge clock_i);
    req_o <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(posedge clock_i);
    // Idle lines show the inverse so stale values cannot pass
    req_o <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    @(negedge clock_i);
    ok = ack_i;
    q  = rdata_i;
    @(posedge clock_i);
    chip_select_low_o <= 1'b1;
  endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the section-three spare register bank
`timescale 1ns/100ps
module testbench;
  import bmsr_pkg::*;
  localparam int CONV = 20;
  logic        clock_i, arst_n_i, hard_rst_low, cs_low, ack, run, done_a, done_b;
  logic        ready_low, check_match;
  logic [15:0] rdata, section_check;
  bmsr_req_t   req;
  int          failures, n_compared, cycles;
  logic [15:0] sh [4];
  logic [7:0]  addrs [4] = '{ADDR_SPARE_A, ADDR_SPARE_HIGH, ADDR_SPARE_B, ADDR_CHECK};

  bmsr_top #(.CONV_COUNT(CONV)) u_dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .hardware_reset_low_i(hard_rst_low),
    .chip_select_low_i(cs_low), .req_i(req), .ack_o(ack), .rdata_o(rdata),
    .conv_run_i(run), .current_converter_a_done_i(done_a),
    .current_converter_b_done_i(done_b), .result_ready_low_o(ready_low),
    .section_check_o(section_check), .check_match_o(check_match));

  bmsr_host u_host (.clock_i(clock_i), .ack_i(ack), .rdata_i(rdata),
    .chip_select_low_o(cs_low), .req_o(req));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [15:0] crc3(input logic [47:0] d);
    logic [15:0] c;
    c = CHECK_SEED;
    for (int i = 47; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CHECK_POLY : 16'h0);
    return c;
  endfunction

  task automatic final_report();
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Ack must follow select exactly
  task automatic rw(input logic sel, input logic wr, input logic [7:0] a,
                    input logic [15:0] d, output logic [15:0] q);
    logic ok;
    u_host.access(sel, wr, a, d, ok, q);
    cmp({15'h0, ok}, {15'h0, sel});
  endtask

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] seed;
    logic [15:0] q;
    int          n, t, idx;
    logic        prev;
    int          f [$];
    seed = 32'h0f77cac0;
    {arst_n_i, hard_rst_low, run, done_a, done_b} = 5'b01000;
    foreach (sh[i]) sh[i] = RESET_WORD;
    repeat (20) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (2) @(negedge clock_i);
    cmp(section_check, crc3(48'h0));
    foreach (addrs[i]) begin
      rw(1'b1, 1'b0, addrs[i], 16'h0, q);
      cmp(q, RESET_WORD);
    end
    rw(1'b1, 1'b1, ADDR_SPARE_HIGH, 16'h00ff, q);
    rw(1'b1, 1'b0, ADDR_SPARE_HIGH, 16'h0, q);
    cmp(q, 16'h0000);
    for (int k = 0; k < 40; k++) begin
      seed = lfsr(seed);
      idx = seed[1:0];
      if (seed[4:2] == 3'h0) begin
        rw(1'b1, 1'b1, 8'h7f, seed[31:16], q);
        rw(1'b1, 1'b0, 8'h7f, 16'h0, q);
        cmp(q, 16'h0000);
      end else begin
        rw(seed[5] | seed[6], 1'b1, addrs[idx], seed[31:16], q);
        if (seed[5] | seed[6]) sh[idx] = (idx == 1) ? seed[31:16] & HIGH_KEEP_MASK : seed[31:16];
        rw(1'b1, 1'b0, addrs[idx], 16'h0, q);
        cmp(q, sh[idx]);
      end
      cmp({15'h0, ready_low}, 16'h0001);
    end
    cmp(section_check, crc3({sh[0], sh[1], sh[2]}));
    rw(1'b1, 1'b1, ADDR_CHECK, crc3({sh[0], sh[1], sh[2]}), q);
    repeat (3) @(negedge clock_i);
    cmp({15'h0, check_match}, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_i);
      if (k == 1) done_b <= 1'b1;
      else done_a <= 1'b1;
      @(posedge clock_i);
      {done_a, done_b} <= 2'b00;
      n = 0;
      repeat (8) begin
        @(negedge clock_i);
        n += (ready_low === 1'b0);
      end
      cmp(16'(n), 16'(READY_LOW_CYCLES));
    end
    @(posedge clock_i);
    run <= 1'b1;
    prev = 1'b1;
    for (t = 0; t < 3 * CONV + 10; t++) begin
      @(negedge clock_i);
      if (prev === 1'b1 && ready_low === 1'b0) f.push_back(t);
      prev = ready_low;
    end
    cmp(16'(f.size() >= 2 ? f[1] - f[0] : 0), 16'(CONV));
    @(posedge clock_i);
    run <= 1'b0;
    hard_rst_low <= 1'b0;
    @(posedge clock_i);
    hard_rst_low <= 1'b1;
    foreach (addrs[i]) begin
      rw(1'b1, 1'b0, addrs[i], 16'h0, q);
      cmp(q, RESET_WORD);
    end
    cmp({15'h0, ready_low}, 16'h0001);
    cmp(section_check, crc3(48'h0));
    cmp({15'h0, check_match}, 16'h0000);
    final_report();
  end
endmodule
